// [hw/scss_pkg.sv]
// Package for the suspend control and status serializer.
// Assumes one 25 MHz clock and a plain address/strobe register port.
package scss_pkg;
	// ==========================================
	// Register map
	localparam logic [15:0] REG_SERIAL_INTERVAL_CONTROL = 16'h8504;
	localparam logic [15:0] REG_CLOCK_STOP_CONTROL = 16'h8508;
	localparam logic [15:0] REG_CPU_EVENT_SHIFT_PACKET = 16'h850c;
	localparam logic [15:0] REG_CONFIG_CTRL_TWO = 16'h00c2;
	localparam logic [15:0] REG_GFX_PIPE = 16'h8304;
	localparam logic [15:0] REG_SUSPEND_REQUEST_N_STATUS = 16'h8510;
	localparam logic [15:0] REG_RANGE_BASE = 16'h8514;
	localparam logic [15:0] REG_RANGE_MASK = 16'h8518;
	// ==========================================
	// Field positions
	localparam int HALT_SUSPEND_REQUEST_N_BIT = 3;
	localparam int PIN_SUSPEND_REQUEST_N_BIT = 7;
	localparam int CLK_STOP_BIT = 0;
	localparam int GFX_PIPE_BIT = 0;
	localparam int INTERVAL_LO = 3;
	localparam int RANGE_HIT_BIT = 1;
	// ==========================================
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PACK_RESET = 8'h00;
	localparam logic GFX_RESET = 1'b1;
	// ==========================================
	// Timing
	localparam int CLOCK_MHZ = 25;
	localparam int HALT_EXIT_CLOCKS = 6;
	localparam int PIN_EXIT_CLOCKS = 2;
	localparam int START_MARK_CLOCKS = 2;
	localparam int END_MARK_CLOCKS = 1;
	// Intervals in microseconds for select codes 0..3
	localparam int INTERVAL_US_0 = 1;
	localparam int INTERVAL_US_1 = 2;
	localparam int INTERVAL_US_2 = 5;
	localparam int INTERVAL_US_3 = 10;
	localparam int INTERVAL_CLK_0 = INTERVAL_US_0 * CLOCK_MHZ;
	localparam int INTERVAL_CLK_1 = INTERVAL_US_1 * CLOCK_MHZ;
	localparam int INTERVAL_CLK_2 = INTERVAL_US_2 * CLOCK_MHZ;
	localparam int INTERVAL_CLK_3 = INTERVAL_US_3 * CLOCK_MHZ;
	// ==========================================
	// Types
	typedef enum logic [2:0] {
		SUSPEND_REQUEST_N_RUN,
		SUSPEND_REQUEST_N_CYCLE_WAIT,
		SUSPEND_REQUEST_N_HALTED,
		SUSPEND_REQUEST_N_PIN,
		SUSPEND_REQUEST_N_LOWV
	} scss_mode_t;
	typedef enum logic [1:0] {
		SER_IDLE,
		SER_START,
		SER_DATA,
		SER_END
	} scss_ser_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} scss_bus_t;
endpackage

// [hw/scss_top.sv]
// Suspend sequencer and serial status packet transmitter.
// Assumes all inputs synchronous to CLOCK; core signals are simple levels.
// Operation
// - Halt with enable: special cycle, then acknowledge
// - Halt suspend exits on interrupt or SMI
// - Drop acknowledge within six clocks, refresh delay
// - PCI master activity drops halt acknowledge
// - Pending PCI access delays halt acknowledge
// - Pin suspend needs enable and idle core
// - Suspend request sampled each rising edge
// - Request inactive drops acknowledge within two
// - Latch one interrupt and SMI each
// - PCI request drops acknowledge, later reasserts
// - PCI access in progress delays acknowledge
// - Clock stop with graphics on ignores request
// - Low voltage: self refresh, then clocks stop
// - Low voltage only leaves on request release
// - Packet sent after each selected 1-10 us idle interval
// - Output low, then two-clock start marker
// - Packet shifted out bit seven first
// - One-clock end marker, then low
// - Packet cleared after transmission
// - Halt suspend stops only core clock
// - Range hit sets packet bit one
`timescale 1ns/100ps
`default_nettype none
module scss_top
#(
	parameter int PACKET_BITS = 8
)
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SRST,
	// Register port
	input wire scss_pkg::scss_bus_t BUS,
	output logic [31:0] READ_DATA,
	// Core events
	input wire logic HALT_INSTRUCTION,
	input wire logic CORE_IDLE,
	input wire logic MASKABLE_IRQ,
	input wire logic IRQ_ENABLED,
	input wire logic SYSMGMT_IRQ_N,
	input wire logic REFRESH_ACTIVE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic MEM_VALID,
	input wire logic [5:0] CPU_EVENTS,
	// PCI side
	input wire logic PCI_MASTER_REQUEST_N,
	input wire logic PCI_MASTER_BUSY,
	input wire logic PCI_REQ_UNMASKED,
	output logic HALT_CYCLE_REQ,
	input wire logic HALT_CYCLE_DONE,
	// Companion side
	input wire logic SUSPEND_REQUEST_N,
	output logic SUSPEND_ACK_N,
	output logic STATUS_SERIAL_OUT,
	// Clock and memory control
	output logic CORE_CLOCK_EN,
	output logic INTERNAL_CLOCK_EN,
	output logic SELF_REFRESH,
	output logic IRQ_PENDING,
	output logic SMI_PENDING
);
	// The shifter and packet map serve only the eight-bit packet
	if (PACKET_BITS != 8)
	begin
		$error("Packet width must be 8");
	end

	// ==========================================
	// Registers
	logic [7:0] cfg_two;
	logic [7:0] ser_ctrl;
	logic clock_stop_enable;
	logic gfx_pipe;
	logic [7:0] packet;
	logic [31:0] range_base;
	logic [31:0] range_mask;
	scss_pkg::scss_mode_t mode;
	scss_pkg::scss_ser_t ser_state;
	logic [2:0] exit_cnt;
	logic [2:0] bit_idx;
	logic [1:0] mark_cnt;
	logic [8:0] interval_cnt;
	logic [8:0] interval_len;
	logic ser_done;
	logic range_hit;
	logic halt_suspend_enable;
	logic pin_suspend_enable;
	logic req_active;
	logic irq_event;
	logic smi_event;
	logic pci_active;

	assign halt_suspend_enable = cfg_two[scss_pkg::HALT_SUSPEND_REQUEST_N_BIT];
	assign pin_suspend_enable = cfg_two[scss_pkg::PIN_SUSPEND_REQUEST_N_BIT];
	// Request sampled as a plain level each rising edge
	assign req_active = ~SUSPEND_REQUEST_N;
	assign irq_event = MASKABLE_IRQ & IRQ_ENABLED;
	assign smi_event = ~SYSMGMT_IRQ_N;
	assign pci_active = PCI_MASTER_BUSY | (~PCI_MASTER_REQUEST_N & PCI_REQ_UNMASKED);
	assign range_hit = MEM_VALID &
		(((MEM_ADDR ^ range_base) & range_mask) == 32'h0000_0000);

	// Register writes; graphics bit is a local mirror of the pipe enable
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			cfg_two <= scss_pkg::CTRL_RESET;
			ser_ctrl <= scss_pkg::CTRL_RESET;
			clock_stop_enable <= 1'b0;
			gfx_pipe <= scss_pkg::GFX_RESET;
			range_base <= 32'h0000_0000;
			range_mask <= 32'h0000_0000;
		end
		else if (BUS.wr)
		begin
			unique case (BUS.addr)
				scss_pkg::REG_CONFIG_CTRL_TWO: cfg_two <= BUS.wdata[7:0];
				scss_pkg::REG_SERIAL_INTERVAL_CONTROL:
					ser_ctrl <= BUS.wdata[7:0];
				scss_pkg::REG_CLOCK_STOP_CONTROL:
					clock_stop_enable <= BUS.wdata[scss_pkg::CLK_STOP_BIT];
				scss_pkg::REG_GFX_PIPE: gfx_pipe <= BUS.wdata[scss_pkg::GFX_PIPE_BIT];
				scss_pkg::REG_RANGE_BASE: range_base <= BUS.wdata;
				scss_pkg::REG_RANGE_MASK: range_mask <= BUS.wdata;
				default: ;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			READ_DATA <= 32'h0000_0000;
		else if (BUS.rd)
		begin
			unique case (BUS.addr)
				scss_pkg::REG_CONFIG_CTRL_TWO: READ_DATA <= {24'h0, cfg_two};
				scss_pkg::REG_SERIAL_INTERVAL_CONTROL:
					READ_DATA <= {24'h0, ser_ctrl};
				scss_pkg::REG_CLOCK_STOP_CONTROL:
					READ_DATA <= {31'h0, clock_stop_enable};
				scss_pkg::REG_GFX_PIPE: READ_DATA <= {31'h0, gfx_pipe};
				scss_pkg::REG_CPU_EVENT_SHIFT_PACKET:
					READ_DATA <= {24'h0, packet};
				scss_pkg::REG_SUSPEND_REQUEST_N_STATUS:
					READ_DATA <= {27'h0, SMI_PENDING, IRQ_PENDING, mode};
				scss_pkg::REG_RANGE_BASE: READ_DATA <= range_base;
				scss_pkg::REG_RANGE_MASK: READ_DATA <= range_mask;
				default: READ_DATA <= 32'h0000_0000;
			endcase
		end
		else
			READ_DATA <= 32'h0000_0000;
	end

	// ==========================================
	// Suspend sequencer
	// One state machine serves halt, pin and low-voltage suspend
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
			exit_cnt <= 3'h0;
		end
		else
		begin
			unique case (mode)
				scss_pkg::SUSPEND_REQUEST_N_RUN:
				begin
					exit_cnt <= 3'h0;
					if (req_active & pin_suspend_enable & CORE_IDLE & ~pci_active)
					begin
						if (clock_stop_enable & gfx_pipe)
							mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
						else if (clock_stop_enable)
							mode <= scss_pkg::SUSPEND_REQUEST_N_LOWV;
						else
							mode <= scss_pkg::SUSPEND_REQUEST_N_PIN;
					end
					else if (HALT_INSTRUCTION & halt_suspend_enable)
						mode <= scss_pkg::SUSPEND_REQUEST_N_CYCLE_WAIT;
				end
				scss_pkg::SUSPEND_REQUEST_N_CYCLE_WAIT:
					if (HALT_CYCLE_DONE & ~PCI_MASTER_BUSY)
						mode <= scss_pkg::SUSPEND_REQUEST_N_HALTED;
				scss_pkg::SUSPEND_REQUEST_N_HALTED:
					// Refresh may hold acknowledge past the nominal bound
					if ((irq_event | smi_event) & ~REFRESH_ACTIVE)
						mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
				scss_pkg::SUSPEND_REQUEST_N_PIN:
					if (~req_active & ~REFRESH_ACTIVE)
						mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
				scss_pkg::SUSPEND_REQUEST_N_LOWV:
					// Nothing but request release is honoured here
					if (~req_active)
						mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
				default: mode <= scss_pkg::SUSPEND_REQUEST_N_RUN;
			endcase
		end
	end

	// Acknowledge follows suspend state; yields to PCI traffic except in low voltage
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			SUSPEND_ACK_N <= 1'b1;
		else if (mode == scss_pkg::SUSPEND_REQUEST_N_HALTED || mode == scss_pkg::SUSPEND_REQUEST_N_PIN)
			SUSPEND_ACK_N <= pci_active;
		else if (mode == scss_pkg::SUSPEND_REQUEST_N_LOWV)
			SUSPEND_ACK_N <= 1'b0;
		else
			SUSPEND_ACK_N <= 1'b1;
	end

	// Halt special cycle strobe held until the PCI side completes it
	assign HALT_CYCLE_REQ = (mode == scss_pkg::SUSPEND_REQUEST_N_CYCLE_WAIT);
	// Core clock gated in suspend; other functions keep their clock except in low voltage
	assign CORE_CLOCK_EN = ~(((mode == scss_pkg::SUSPEND_REQUEST_N_HALTED) |
		(mode == scss_pkg::SUSPEND_REQUEST_N_PIN)) & ~SUSPEND_ACK_N) &
		(mode != scss_pkg::SUSPEND_REQUEST_N_LOWV);
	assign SELF_REFRESH = (mode == scss_pkg::SUSPEND_REQUEST_N_LOWV);
	// Internal clocks stop only once self refresh is in place
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			INTERNAL_CLOCK_EN <= 1'b1;
		else
			INTERNAL_CLOCK_EN <= ~SELF_REFRESH;
	end

	// Interrupts arriving in pin suspend held once for later service
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			IRQ_PENDING <= 1'b0;
			SMI_PENDING <= 1'b0;
		end
		else if (mode == scss_pkg::SUSPEND_REQUEST_N_PIN)
		begin
			IRQ_PENDING <= IRQ_PENDING | irq_event;
			SMI_PENDING <= SMI_PENDING | smi_event;
		end
		else if (mode == scss_pkg::SUSPEND_REQUEST_N_RUN)
		begin
			IRQ_PENDING <= 1'b0;
			SMI_PENDING <= 1'b0;
		end
	end

	// ==========================================
	// Serial packet transmitter
	always_comb
	begin
		unique case (ser_ctrl[scss_pkg::INTERVAL_LO +: 2])
			2'h0: interval_len = 9'(scss_pkg::INTERVAL_CLK_0);
			2'h1: interval_len = 9'(scss_pkg::INTERVAL_CLK_1);
			2'h2: interval_len = 9'(scss_pkg::INTERVAL_CLK_2);
			default: interval_len = 9'(scss_pkg::INTERVAL_CLK_3);
		endcase
	end

	assign ser_done = (ser_state == scss_pkg::SER_END);

	// Events accumulate; clear after send, but a new event wins
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			packet <= scss_pkg::PACK_RESET;
		else if (BUS.wr &&
			BUS.addr == scss_pkg::REG_CPU_EVENT_SHIFT_PACKET)
			packet <= BUS.wdata[7:0];
		else
			packet <= (ser_done ? 8'h00 : packet) |
				{CPU_EVENTS, range_hit, 1'b0};
	end

	// Interval, markers and data shift; one bit each clock
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			ser_state <= scss_pkg::SER_IDLE;
			interval_cnt <= 9'h000;
			bit_idx <= 3'h7;
			mark_cnt <= 2'h0;
			STATUS_SERIAL_OUT <= 1'b0;
		end
		else
		begin
			unique case (ser_state)
				scss_pkg::SER_IDLE:
				begin
					STATUS_SERIAL_OUT <= 1'b0;
					if (interval_cnt >= interval_len - 9'h001)
					begin
						interval_cnt <= 9'h000;
						ser_state <= scss_pkg::SER_START;
						mark_cnt <= 2'h0;
						STATUS_SERIAL_OUT <= 1'b1;
					end
					else
						interval_cnt <= interval_cnt + 9'h001;
				end
				scss_pkg::SER_START:
				begin
					if (mark_cnt == 2'(scss_pkg::START_MARK_CLOCKS - 1))
					begin
						ser_state <= scss_pkg::SER_DATA;
						bit_idx <= 3'h7;
						STATUS_SERIAL_OUT <= packet[7];
					end
					mark_cnt <= mark_cnt + 2'h1;
				end
				scss_pkg::SER_DATA:
				begin
					if (bit_idx == 3'h0)
					begin
						ser_state <= scss_pkg::SER_END;
						STATUS_SERIAL_OUT <= 1'b1;
					end
					else
						STATUS_SERIAL_OUT <= packet[bit_idx - 3'h1];
					bit_idx <= bit_idx - 3'h1;
				end
				scss_pkg::SER_END:
				begin
					ser_state <= scss_pkg::SER_IDLE;
					STATUS_SERIAL_OUT <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// Checks
	sequence start_mark_s;
		ser_state == scss_pkg::SER_IDLE ##1 ser_state == scss_pkg::SER_START;
	endsequence

	start_two_a: assert property (@(posedge CLOCK) disable iff (SRST)
		start_mark_s |-> STATUS_SERIAL_OUT [*2])
		else $error("start marker not two clocks");
	end_one_a: assert property (@(posedge CLOCK) disable iff (SRST)
		ser_state == scss_pkg::SER_END |-> STATUS_SERIAL_OUT ##1 !STATUS_SERIAL_OUT)
		else $error("end marker wrong");
	data_len_a: assert property (@(posedge CLOCK) disable iff (SRST)
		$rose(ser_state == scss_pkg::SER_DATA) |->
		(ser_state == scss_pkg::SER_DATA) [*8] ##1 ser_state == scss_pkg::SER_END)
		else $error("data phase not eight clocks");
	pkt_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
		ser_done && !BUS.wr && CPU_EVENTS == 6'h00 && !range_hit |=> packet == 8'h00)
		else $error("packet not cleared");
	gfx_block_a: assert property (@(posedge CLOCK) disable iff (SRST)
		mode == scss_pkg::SUSPEND_REQUEST_N_RUN && clock_stop_enable && gfx_pipe
		|=> mode != scss_pkg::SUSPEND_REQUEST_N_LOWV && mode != scss_pkg::SUSPEND_REQUEST_N_PIN)
		else $error("suspend taken with graphics on");
	pin_exit_a: assert property (@(posedge CLOCK) disable iff (SRST)
		mode == scss_pkg::SUSPEND_REQUEST_N_PIN && !req_active && !REFRESH_ACTIVE
		|-> ##[1:2] SUSPEND_ACK_N)
		else $error("acknowledge not dropped in two");
	halt_exit_a: assert property (@(posedge CLOCK) disable iff (SRST)
		mode == scss_pkg::SUSPEND_REQUEST_N_HALTED && (irq_event || smi_event) &&
		!REFRESH_ACTIVE
		|-> ##[1:6] SUSPEND_ACK_N)
		else $error("acknowledge not dropped in six");
	pci_hold_a: assert property (@(posedge CLOCK) disable iff (SRST)
		mode != scss_pkg::SUSPEND_REQUEST_N_LOWV && pci_active |=> SUSPEND_ACK_N)
		else $error("acknowledge during PCI activity");
	halt_seq_a: assert property (@(posedge CLOCK) disable iff (SRST)
		$fell(SUSPEND_ACK_N) |-> $past(mode) != scss_pkg::SUSPEND_REQUEST_N_RUN)
		else $error("acknowledge without suspend entry");
	pin_gate_a: assert property (@(posedge CLOCK) disable iff (SRST)
		mode == scss_pkg::SUSPEND_REQUEST_N_RUN && !pin_suspend_enable
		|=> mode != scss_pkg::SUSPEND_REQUEST_N_PIN && mode != scss_pkg::SUSPEND_REQUEST_N_LOWV)
		else $error("pin suspend without enable");
endmodule
`default_nettype wire

// [test/scss_companion.sv]
// Companion chip model: drives the suspend request, decodes packets.
// Assumes the serial line changes just after rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module scss_companion
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link
	input wire logic want_suspend,
	output logic suspend_request_n,
	input wire logic serial_in,
	// Decoded results
	output logic [7:0] packet,
	output logic [15:0] n_packets,
	output logic [15:0] gap,
	output logic [7:0] frame_errs
);
	logic prev;
	logic [3:0] bits;
	logic [7:0] shift;
	logic [15:0] since;
	// ==========================================
	// Request launched just after the edge
	always_ff @(posedge clk)
		suspend_request_n <= srst | !want_suspend;
	// ==========================================
	// Receiver: two highs start a frame, gap counts start to start
	always_ff @(posedge clk)
	begin
		prev <= serial_in;
		since <= since + 16'h1;
		if (srst)
		begin
			bits <= 4'h0;
			n_packets <= 16'h0;
			frame_errs <= 8'h0;
			since <= 16'h0;
		end
		else if (bits == 4'h0)
		begin
			if (serial_in && prev)
			begin
				bits <= 4'h9;
				gap <= since;
				since <= 16'h1;
			end
		end
		else if (bits == 4'h1)
		begin
			// End marker missing counts as a framing fault
			bits <= 4'h0;
			prev <= 1'b0;
			packet <= shift;
			n_packets <= n_packets + 16'h1;
			if (!serial_in)
				frame_errs <= frame_errs + 8'h1;
		end
		else
		begin
			bits <= bits - 4'h1;
			shift <= {shift[6:0], serial_in};
		end
	end
endmodule
`default_nettype wire

// [test/scss_top_tb.sv]
// Self-checking bench for the suspend sequencer and packet serializer.
// Assumes the companion model of scss_companion.sv.
`timescale 1ns/100ps
`default_nettype none
module scss_top_tb;
	logic CLOCK = 1'b0;
	logic SRST = 1'b1;
	logic clk_run = 1'b1;
	scss_pkg::scss_bus_t BUS = '0;
	logic [31:0] READ_DATA;
	logic [31:0] MEM_ADDR = '0;
	logic [5:0] CPU_EVENTS = '0;
	logic HALT_INSTRUCTION = 0, MASKABLE_IRQ = 0, SYSMGMT_IRQ_N = 1;
	logic MEM_VALID = 0, PCI_MASTER_REQUEST_N = 1, PCI_MASTER_BUSY = 0;
	logic HALT_CYCLE_DONE = 0, want = 0;
	logic CORE_IDLE = 1, IRQ_ENABLED = 1, REFRESH_ACTIVE = 0;
	logic PCI_REQ_UNMASKED = 1;
	logic HALT_CYCLE_REQ, SUSPEND_REQUEST_N, SUSPEND_ACK_N;
	logic STATUS_SERIAL_OUT, CORE_CLOCK_EN, INTERNAL_CLOCK_EN;
	logic SELF_REFRESH, IRQ_PENDING, SMI_PENDING;
	logic [7:0] packet, ferr;
	logic [15:0] npk, gap;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// ==========================================
	// Clock, stoppable for the low-voltage case
	always #20 if (clk_run) CLOCK = ~CLOCK;
	// ==========================================
	// Design and companion
	scss_top dut (.CLOCK, .SRST, .BUS, .READ_DATA, .HALT_INSTRUCTION,
		.CORE_IDLE, .MASKABLE_IRQ, .IRQ_ENABLED, .SYSMGMT_IRQ_N,
		.REFRESH_ACTIVE, .MEM_ADDR, .MEM_VALID, .CPU_EVENTS,
		.PCI_MASTER_REQUEST_N, .PCI_MASTER_BUSY, .PCI_REQ_UNMASKED,
		.HALT_CYCLE_REQ, .HALT_CYCLE_DONE, .SUSPEND_REQUEST_N,
		.SUSPEND_ACK_N, .STATUS_SERIAL_OUT, .CORE_CLOCK_EN,
		.INTERNAL_CLOCK_EN, .SELF_REFRESH, .IRQ_PENDING, .SMI_PENDING);
	scss_companion partner (.clk(CLOCK), .srst(SRST), .want_suspend(want),
		.suspend_request_n(SUSPEND_REQUEST_N),
		.serial_in(STATUS_SERIAL_OUT), .packet(packet), .n_packets(npk),
		.gap(gap), .frame_errs(ferr));
	// ==========================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLOCK);
		BUS.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge CLOCK);
		BUS <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge CLOCK);
		BUS.rd <= 1'b0;
		#1 d = READ_DATA;
	endtask
	task automatic wait_ack(input logic v, input int lim);
		int n = 0;
		#1;
		while (SUSPEND_ACK_N !== v && n < lim)
		begin
			@(posedge CLOCK);
			#1;
			n++;
		end
		check(SUSPEND_ACK_N, v);
	endtask
	task automatic hold_ack(input logic v, input int n);
		repeat (n)
		begin
			@(posedge CLOCK);
			#1;
			check(SUSPEND_ACK_N, v);
		end
	endtask
	task automatic next_pkt();
		logic [15:0] n0 = npk;
		int t = 0;
		while (npk === n0 && t < 600)
		begin
			@(posedge CLOCK);
			t++;
		end
		#1;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		rd(scss_pkg::REG_SERIAL_INTERVAL_CONTROL, d);
		check(d[7:0], scss_pkg::CTRL_RESET);
		rd(scss_pkg::REG_GFX_PIPE, d);
		check(d[0], scss_pkg::GFX_RESET);
		rd(16'h8600, d);
		check(d, 32'h0);
		$display("register test done");
	endtask
	task automatic t_serial();
		int ivl [4];
		ivl = '{scss_pkg::INTERVAL_CLK_0, scss_pkg::INTERVAL_CLK_1,
			scss_pkg::INTERVAL_CLK_2, scss_pkg::INTERVAL_CLK_3};
		for (int c = 0; c < 4; c++)
		begin
			wr(scss_pkg::REG_SERIAL_INTERVAL_CONTROL, 32'(c) << 3);
			next_pkt();
			wr(scss_pkg::REG_CPU_EVENT_SHIFT_PACKET, 32'hc1);
			next_pkt();
			check(packet, 8'hc1);
			next_pkt();
			check(packet, 8'h00);
			check(gap, ivl[c] + 11);
		end
		check(ferr, 8'h00);
		$display("serial test done");
	endtask
	task automatic t_range();
		logic [31:0] d;
		wr(scss_pkg::REG_RANGE_BASE, 32'h1000);
		wr(scss_pkg::REG_RANGE_MASK, 32'hfffff000);
		next_pkt();
		@(posedge CLOCK);
		MEM_ADDR <= 32'h2000;
		MEM_VALID <= 1'b1;
		@(posedge CLOCK);
		MEM_VALID <= 1'b0;
		rd(scss_pkg::REG_CPU_EVENT_SHIFT_PACKET, d);
		check(d, 32'h0);
		@(posedge CLOCK);
		MEM_ADDR <= 32'h1234;
		MEM_VALID <= 1'b1;
		CPU_EVENTS <= 6'h21;
		@(posedge CLOCK);
		MEM_VALID <= 1'b0;
		CPU_EVENTS <= 6'h0;
		rd(scss_pkg::REG_CPU_EVENT_SHIFT_PACKET, d);
		check(d, 32'h86);
		next_pkt();
		check(packet, 8'h86);
		$display("range test done");
	endtask
	// Halt with a master busy; special cycle done early, so only the
	// busy master can hold acknowledge off
	task automatic halt_in(input int busy);
		@(posedge CLOCK);
		HALT_INSTRUCTION <= 1'b1;
		PCI_MASTER_BUSY <= (busy != 0);
		@(posedge CLOCK);
		HALT_INSTRUCTION <= 1'b0;
		HALT_CYCLE_DONE <= 1'b1;
		#1;
		check(HALT_CYCLE_REQ, 1'b1);
		check(SUSPEND_ACK_N, 1'b1);
		hold_ack(1'b1, busy);
		@(posedge CLOCK);
		PCI_MASTER_BUSY <= 1'b0;
		@(posedge CLOCK);
		HALT_CYCLE_DONE <= 1'b0;
		wait_ack(1'b0, 4);
		check(HALT_CYCLE_REQ, 1'b0);
	endtask
	task automatic t_halt();
		wr(scss_pkg::REG_CONFIG_CTRL_TWO, 32'h08);
		halt_in(6);
		check(CORE_CLOCK_EN, 1'b0);
		check(INTERNAL_CLOCK_EN, 1'b1);
		@(posedge CLOCK);
		PCI_MASTER_BUSY <= 1'b1;
		PCI_MASTER_REQUEST_N <= 1'b0;
		wait_ack(1'b1, 4);
		hold_ack(1'b1, 3);
		@(posedge CLOCK);
		PCI_MASTER_BUSY <= 1'b0;
		PCI_MASTER_REQUEST_N <= 1'b1;
		wait_ack(1'b0, 4);
		@(posedge CLOCK);
		IRQ_ENABLED <= 1'b0;
		MASKABLE_IRQ <= 1'b1;
		hold_ack(1'b0, 4);
		@(posedge CLOCK);
		IRQ_ENABLED <= 1'b1;
		wait_ack(1'b1, scss_pkg::HALT_EXIT_CLOCKS + 1);
		@(posedge CLOCK);
		MASKABLE_IRQ <= 1'b0;
		halt_in(0);
		@(posedge CLOCK);
		SYSMGMT_IRQ_N <= 1'b0;
		wait_ack(1'b1, scss_pkg::HALT_EXIT_CLOCKS + 1);
		@(posedge CLOCK);
		SYSMGMT_IRQ_N <= 1'b1;
		$display("halt test done");
	endtask
	task automatic t_pin();
		wr(scss_pkg::REG_CONFIG_CTRL_TWO, 32'h80);
		@(posedge CLOCK);
		PCI_MASTER_BUSY <= 1'b1;
		want <= 1'b1;
		hold_ack(1'b1, 5);
		@(posedge CLOCK);
		PCI_MASTER_BUSY <= 1'b0;
		CORE_IDLE <= 1'b0;
		hold_ack(1'b1, 4);
		@(posedge CLOCK);
		CORE_IDLE <= 1'b1;
		wait_ack(1'b0, 4);
		@(posedge CLOCK);
		MASKABLE_IRQ <= 1'b1;
		SYSMGMT_IRQ_N <= 1'b0;
		@(posedge CLOCK);
		MASKABLE_IRQ <= 1'b0;
		SYSMGMT_IRQ_N <= 1'b1;
		hold_ack(1'b0, 2);
		check({IRQ_PENDING, SMI_PENDING}, 2'b11);
		@(posedge CLOCK);
		PCI_MASTER_REQUEST_N <= 1'b0;
		wait_ack(1'b1, 4);
		@(posedge CLOCK);
		PCI_MASTER_REQUEST_N <= 1'b1;
		wait_ack(1'b0, 4);
		// A masked request leaves the acknowledge low
		@(posedge CLOCK);
		PCI_REQ_UNMASKED <= 1'b0;
		PCI_MASTER_REQUEST_N <= 1'b0;
		hold_ack(1'b0, 3);
		@(posedge CLOCK);
		PCI_REQ_UNMASKED <= 1'b1;
		PCI_MASTER_REQUEST_N <= 1'b1;
		// Refresh in progress holds the exit back
		want <= 1'b0;
		REFRESH_ACTIVE <= 1'b1;
		hold_ack(1'b0, 5);
		@(posedge CLOCK);
		REFRESH_ACTIVE <= 1'b0;
		wait_ack(1'b1, scss_pkg::PIN_EXIT_CLOCKS + 2);
		$display("pin test done");
	endtask
	task automatic t_lowv();
		wr(scss_pkg::REG_CLOCK_STOP_CONTROL, 32'h1);
		@(posedge CLOCK);
		want <= 1'b1;
		hold_ack(1'b1, 8);
		@(posedge CLOCK);
		want <= 1'b0;
		wr(scss_pkg::REG_GFX_PIPE, 32'h0);
		@(posedge CLOCK);
		want <= 1'b1;
		wait_ack(1'b0, 6);
		check({SELF_REFRESH, INTERNAL_CLOCK_EN}, 2'b10);
		@(posedge CLOCK);
		PCI_MASTER_REQUEST_N <= 1'b0;
		hold_ack(1'b0, 4);
		@(posedge CLOCK);
		PCI_MASTER_REQUEST_N <= 1'b1;
		#1 clk_run = 1'b0;
		#400 want = 1'b0;
		#400 clk_run = 1'b1;
		wait_ack(1'b1, scss_pkg::PIN_EXIT_CLOCKS + 3);
		$display("low-voltage test done");
	endtask
	// ==========================================
	// Closing report, reached once
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Ceiling well above the roughly 2200 cycles of the run
	always @(posedge CLOCK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	// ==========================================
	// Main sequence; pending flags clear on return to run, so no interrupt stays latched
	initial
	begin
		repeat (20) @(posedge CLOCK);
		SRST <= 1'b0;
		t_regs();
		t_serial();
		t_range();
		t_halt();
		t_pin();
		t_lowv();
		print_verdict();
	end
endmodule
`default_nettype wire
